// ===== shared/pcsl_pkg.sv
package pcsl_pkg;
   // ****************************************
   // Clock and soft reset timing
   // ****************************************
   localparam int  CLK_HZ            = 10_000_000;
   localparam real SOFT_RESET_S      = 0.5;
   localparam int  SOFT_RESET_CYCLES = int'($floor(SOFT_RESET_S * CLK_HZ));

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [3:0] OFS_CTRL    = 4'h0;
   localparam logic [3:0] OFS_ADV     = 4'h4;
   localparam logic [3:0] OFS_SPECIAL = 4'h8;
   localparam logic [3:0] OFS_STRAPS  = 4'hC;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_SOFT_RESET = 15;
   localparam int CTRL_SPEED      = 13;
   localparam int CTRL_ANEG       = 12;
   localparam int CTRL_POWER_DOWN = 11;
   localparam int CTRL_ISOLATE    = 10;
   localparam int CTRL_DUPLEX     = 8;
   localparam int ADV_LSB         = 5;
   localparam int SPC_IFMODE      = 14;
   localparam int SPC_MODE_LSB    = 5;
   localparam int STS_BUSY        = 16;
   localparam int STS_POWER_DOWN  = 17;
   localparam int STS_RMII        = 8;
   localparam int STS_MODE_LSB    = 5;

   // ****************************************
   // Reset values and mode codes
   // ****************************************
   localparam logic [4:0] ADDR_RESET   = 5'h00;
   localparam logic [2:0] MODE_RESET   = 3'h0;
   localparam logic       DC_SPEED     = 1'b1;
   localparam logic       DC_DUPLEX    = 1'b0;
   localparam logic [3:0] CFG_10HD     = 4'h0;
   localparam logic [3:0] CFG_10FD     = 4'h1;
   localparam logic [3:0] CFG_100HD    = 4'h8;
   localparam logic [3:0] CFG_100FD    = 4'h9;
   localparam logic [3:0] CFG_AN100HD  = 4'hC;
   localparam logic [3:0] ADV_100HD    = 4'h4;
   localparam logic [3:0] ADV_ALL      = 4'hF;
   localparam logic [3:0] ADV_RESET    = 4'h0;

   typedef enum logic [2:0] {
      PCSL_M10HD, PCSL_M10FD, PCSL_M100HD, PCSL_M100FD,
      PCSL_MAN100HD, PCSL_MREPEATER, PCSL_MPOWERDOWN, PCSL_MALL
   } pcsl_mode_t;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== shared/pcsl_timer_if.sv
`timescale 1ns/1ps
interface pcsl_timer_if;
   logic start;
   logic busy;
   logic done;
   modport ctl (output start, input busy, input done);
   modport tmr (input start, output busy, output done);
endinterface

// ===== hw/pcsl_reset_timer.sv
`timescale 1ns/1ps
module pcsl_reset_timer #(
   parameter int CYCLES = pcsl_pkg::SOFT_RESET_CYCLES
) (
   // Clock and reset
   input wire logic         clk,
   input wire logic         srst,
   // Control side
   pcsl_timer_if.tmr        tif
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef enum logic {PCSL_TIDLE, PCSL_TRUN} pcsl_tstate_t;

   pcsl_tstate_t   state_r;
   pcsl_tstate_t   state_nxt;
   logic [CW-1:0]  count_r;
   logic [CW-1:0]  count_nxt;
   logic           done_r;
   logic           done_nxt;

   always_comb begin
      state_nxt = state_r;
      count_nxt = count_r;
      done_nxt  = 1'b0;
      unique case (state_r)
         PCSL_TIDLE: begin
            if (tif.start) begin
               state_nxt = PCSL_TRUN;
               count_nxt = CW'(CYCLES - 1);
            end
         end
         PCSL_TRUN: begin
            // Ends no later than the longest allowed reset time
            if (count_r == '0) begin
               state_nxt = PCSL_TIDLE;
               done_nxt  = 1'b1;
            end else begin
               count_nxt = count_r - CW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= PCSL_TIDLE;
         count_r <= '0;
         done_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         done_r  <= done_nxt;
      end
   end

   assign tif.busy = (state_r == PCSL_TRUN);
   assign tif.done = done_r;
endmodule

// ===== hw/pcsl_top.sv
`timescale 1ns/1ps
// Behaviour
// - Straps sampled at power-on reset and at pin reset, captured values kept
// - Three address straps stored at end of hardware reset, default zero
// - Management frames answered only when their address matches stored address
// - Stored management address seeds the transmit scrambler
// - Straps give 0..7; software may write address field, then it is used
// - Address bits 0,1,2 from rx-error, rx-clock and rxd3 pins
// - On pin reset release, mode strap loads speed, duplex, aneg, advertisement
// - Soft reset keeps current register bits except power-down, set if mode field is 110; mode strap not reapplied
// - Code 000 gives control 0000, advertisement untouched
// - Code 001 gives control 0001
// - Code 010 gives control 1000, carrier sense on transmit and receive
// - Code 011 gives control 1001, carrier sense on receive only
// - Code 100 gives control 1100, advertisement 0100, CRS on tx and rx
// - Code 101 repeater, control 1100, advertisement 0100, CRS on receive
// - Code 110 powers down until mode field rewritten and soft reset
// - Code 111 gives control X10X and advertisement 1111
// - Mode bits 0,1,2 from rxd0, rxd1 and collision pins
// - Reduced interface strap latched at reset release, low means full MII
// - Interface mode bit loaded from that strap and reports active mode
// - Soft reset bit self-clears within 0.5 s, retained bits keep values
module pcsl_top #(
   parameter int SOFT_RESET_CYCLES = pcsl_pkg::SOFT_RESET_CYCLES
) (
   // Clock, power-on reset and pin reset
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        pinResetLow,
   // Strap pins shared with receive outputs
   input  wire logic        rxErrPin,
   input  wire logic        rxClkPin,
   input  wire logic        rxd3Pin,
   input  wire logic        rxd0Pin,
   input  wire logic        rxd1Pin,
   input  wire logic        colPin,
   input  wire logic        reducedIfSelPin,
   // Management frame address check
   input  wire logic        frameValid,
   input  wire logic [4:0]  frameAddr,
   output logic             frameAccept,
   // Configuration of the 10/100 logic
   output logic             speed100,
   output logic             fullDuplex,
   output logic             anegEnable,
   output logic             isolate,
   output logic [3:0]       advAbility,
   output logic             powerDown,
   output logic             crsOnTransmit,
   output logic             repeaterMode,
   output logic             interfaceModeBit,
   output logic [4:0]       scramblerSeed,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // ****************************************
   // Mode decode
   // ****************************************
   // Returns {control[13,12,10,8], advertisement[8:5], advertisement loaded}
   function automatic logic [8:0] decodeMode(input logic [2:0] code);
      logic [8:0] r;
      r = {pcsl_pkg::CFG_10HD, pcsl_pkg::ADV_RESET, 1'b0};
      unique case (pcsl_pkg::pcsl_mode_t'(code))
         pcsl_pkg::PCSL_M10HD:      r = {pcsl_pkg::CFG_10HD, pcsl_pkg::ADV_RESET, 1'b0};
         pcsl_pkg::PCSL_M10FD:      r = {pcsl_pkg::CFG_10FD, pcsl_pkg::ADV_RESET, 1'b0};
         pcsl_pkg::PCSL_M100HD:     r = {pcsl_pkg::CFG_100HD, pcsl_pkg::ADV_RESET, 1'b0};
         pcsl_pkg::PCSL_M100FD:     r = {pcsl_pkg::CFG_100FD, pcsl_pkg::ADV_RESET, 1'b0};
         pcsl_pkg::PCSL_MAN100HD:   r = {pcsl_pkg::CFG_AN100HD, pcsl_pkg::ADV_100HD, 1'b1};
         pcsl_pkg::PCSL_MREPEATER:  r = {pcsl_pkg::CFG_AN100HD, pcsl_pkg::ADV_100HD, 1'b1};
         pcsl_pkg::PCSL_MPOWERDOWN: r = {pcsl_pkg::CFG_10HD, pcsl_pkg::ADV_RESET, 1'b0};
         pcsl_pkg::PCSL_MALL:       r = {pcsl_pkg::DC_SPEED, 2'b10, pcsl_pkg::DC_DUPLEX,
                                         pcsl_pkg::ADV_ALL, 1'b1};
      endcase
      return r;
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [7:0] syncA_r;
   logic [7:0] syncB_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         syncA_r <= 8'h00;
         syncB_r <= 8'h00;
      end else begin
         syncA_r <= {pinResetLow, reducedIfSelPin, colPin, rxd1Pin, rxd0Pin, rxd3Pin, rxClkPin, rxErrPin};
         syncB_r <= syncA_r;
      end
   end

   logic       pinInReset;
   logic [2:0] addrStrap;
   logic [2:0] modeStrap;
   logic       rmiiStrap;
   logic       hwReset;
   assign pinInReset = !syncB_r[7];
   assign addrStrap  = syncB_r[2:0];
   assign modeStrap  = syncB_r[5:3];
   assign rmiiStrap  = syncB_r[6];
   assign hwReset    = pinInReset;

   // ****************************************
   // Soft reset timer
   // ****************************************
   pcsl_timer_if tif ();

   pcsl_reset_timer #(
      .CYCLES (SOFT_RESET_CYCLES)
   ) u_timer (
      .clk  (clk),
      .srst (srst),
      .tif  (tif)
   );

   // ****************************************
   // Registers and bus state
   // ****************************************
   logic        hwRstSeen_r,  hwRstSeen_nxt;
   logic [3:0]  ctrl_r,       ctrl_nxt;      // {speed, aneg, isolate, duplex}
   logic        pd_r,         pd_nxt;
   logic [3:0]  adv_r,        adv_nxt;
   logic [4:0]  addr_r,       addr_nxt;
   logic [2:0]  mode_r,       mode_nxt;
   logic        ifMode_r,     ifMode_nxt;
   logic [6:0]  strapLatch_r, strapLatch_nxt;
   logic        crsTx_r,      crsTx_nxt;
   logic        rep_r,        rep_nxt;
   logic        accept_r,     accept_nxt;
   logic        start_r,      start_nxt;
   logic        awHave_r,     awHave_nxt;
   logic        wHave_r,      wHave_nxt;
   logic [3:0]  awAddr_r,     awAddr_nxt;
   logic [31:0] wData_r,      wData_nxt;
   logic        wStrbOk_r,    wStrbOk_nxt;
   logic        awRdy_r,      awRdy_nxt;
   logic        wRdy_r,       wRdy_nxt;
   logic        bValid_r,     bValid_nxt;
   logic [1:0]  bResp_r,      bResp_nxt;
   logic        arRdy_r,      arRdy_nxt;
   logic        rValid_r,     rValid_nxt;
   logic [31:0] rData_r,      rData_nxt;
   logic [1:0]  rResp_r,      rResp_nxt;
   logic [8:0]  dec;
   logic        doWrite;
   logic        loadPulse;

   assign loadPulse = hwRstSeen_r && !hwReset;
   assign dec       = decodeMode(modeStrap);
   assign doWrite   = awHave_r && wHave_r && !bValid_r;

   function automatic logic [31:0] readReg(input logic [3:0] a, input logic [3:0] c, input logic p,
                                           input logic [3:0] ad, input logic [4:0] ma, input logic [2:0] md,
                                           input logic im, input logic [6:0] sl, input logic bz);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         pcsl_pkg::OFS_CTRL: begin
            v[pcsl_pkg::CTRL_SOFT_RESET] = bz;
            v[pcsl_pkg::CTRL_SPEED]      = c[3];
            v[pcsl_pkg::CTRL_ANEG]       = c[2];
            v[pcsl_pkg::CTRL_POWER_DOWN] = p;
            v[pcsl_pkg::CTRL_ISOLATE]    = c[1];
            v[pcsl_pkg::CTRL_DUPLEX]     = c[0];
         end
         pcsl_pkg::OFS_ADV:     v[pcsl_pkg::ADV_LSB +: 4] = ad;
         pcsl_pkg::OFS_SPECIAL: begin
            v[pcsl_pkg::SPC_IFMODE]         = im;
            v[pcsl_pkg::SPC_MODE_LSB +: 3]  = md;
            v[4:0]                          = ma;
         end
         pcsl_pkg::OFS_STRAPS: begin
            v[pcsl_pkg::STS_POWER_DOWN]     = p;
            v[pcsl_pkg::STS_BUSY]           = bz;
            v[pcsl_pkg::STS_RMII]           = sl[6];
            v[pcsl_pkg::STS_MODE_LSB +: 3]  = sl[5:3];
            v[2:0]                          = sl[2:0];
         end
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [3:0] a);
      return a == pcsl_pkg::OFS_CTRL || a == pcsl_pkg::OFS_ADV ||
             a == pcsl_pkg::OFS_SPECIAL || a == pcsl_pkg::OFS_STRAPS;
   endfunction

   always_comb begin
      hwRstSeen_nxt  = hwReset;
      ctrl_nxt       = ctrl_r;
      pd_nxt         = pd_r;
      adv_nxt        = adv_r;
      addr_nxt       = addr_r;
      mode_nxt       = mode_r;
      ifMode_nxt     = ifMode_r;
      strapLatch_nxt = strapLatch_r;
      crsTx_nxt      = crsTx_r;
      rep_nxt        = rep_r;
      start_nxt      = 1'b0;
      accept_nxt     = frameValid && (frameAddr == addr_r);
      awHave_nxt     = awHave_r;
      wHave_nxt      = wHave_r;
      awAddr_nxt     = awAddr_r;
      wData_nxt      = wData_r;
      wStrbOk_nxt    = wStrbOk_r;
      bValid_nxt     = bValid_r && !s_axi_bready;
      bResp_nxt      = bResp_r;
      rValid_nxt     = rValid_r && !s_axi_rready;
      rData_nxt      = rData_r;
      rResp_nxt      = rResp_r;
      if (s_axi_awvalid && awRdy_r) begin
         awHave_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wRdy_r) begin
         wHave_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         // Strobes only mean something while wvalid stands
         wStrbOk_nxt = (s_axi_wstrb[1:0] == 2'b11);
      end
      if (doWrite) begin
         awHave_nxt = 1'b0;
         wHave_nxt  = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt  = mapped(awAddr_r) ? pcsl_pkg::RESP_OKAY : pcsl_pkg::RESP_SLVERR;
         // Writes during a soft reset are dropped but still answered
         if (!tif.busy && wStrbOk_r) begin
            if (awAddr_r == pcsl_pkg::OFS_CTRL) begin
               ctrl_nxt = {wData_r[pcsl_pkg::CTRL_SPEED], wData_r[pcsl_pkg::CTRL_ANEG],
                           wData_r[pcsl_pkg::CTRL_ISOLATE], wData_r[pcsl_pkg::CTRL_DUPLEX]};
               pd_nxt   = wData_r[pcsl_pkg::CTRL_POWER_DOWN];
               start_nxt = wData_r[pcsl_pkg::CTRL_SOFT_RESET];
            end
            if (awAddr_r == pcsl_pkg::OFS_ADV) begin
               adv_nxt = wData_r[pcsl_pkg::ADV_LSB +: 4];
            end
            if (awAddr_r == pcsl_pkg::OFS_SPECIAL) begin
               addr_nxt = wData_r[4:0];
               mode_nxt = wData_r[pcsl_pkg::SPC_MODE_LSB +: 3];
            end
         end
      end
      if (s_axi_arvalid && arRdy_r) begin
         rValid_nxt = 1'b1;
         rResp_nxt  = mapped(s_axi_araddr) ? pcsl_pkg::RESP_OKAY : pcsl_pkg::RESP_SLVERR;
         rData_nxt  = readReg(s_axi_araddr, ctrl_r, pd_r, adv_r, addr_r, mode_r, ifMode_r, strapLatch_r,
                              tif.busy || start_r);
      end
      // Register bits are the only source at soft reset completion
      if (tif.done) begin
         pd_nxt    = (mode_r == 3'(pcsl_pkg::PCSL_MPOWERDOWN));
         crsTx_nxt = !ctrl_r[0] && (mode_r != 3'(pcsl_pkg::PCSL_MREPEATER));
         rep_nxt   = (mode_r == 3'(pcsl_pkg::PCSL_MREPEATER));
      end
      if (hwReset) begin
         ctrl_nxt  = pcsl_pkg::CFG_10HD;
         pd_nxt    = 1'b0;
         adv_nxt   = pcsl_pkg::ADV_RESET;
         addr_nxt  = pcsl_pkg::ADDR_RESET;
         mode_nxt  = pcsl_pkg::MODE_RESET;
         start_nxt = 1'b0;
      end else if (loadPulse) begin
         strapLatch_nxt = {rmiiStrap, modeStrap, addrStrap};
         addr_nxt       = {2'b00, addrStrap};
         mode_nxt       = modeStrap;
         ctrl_nxt       = dec[8:5];
         if (dec[0]) begin
            adv_nxt = dec[4:1];
         end
         pd_nxt     = (modeStrap == 3'(pcsl_pkg::PCSL_MPOWERDOWN));
         crsTx_nxt  = !dec[5] && (modeStrap != 3'(pcsl_pkg::PCSL_MREPEATER));
         rep_nxt    = (modeStrap == 3'(pcsl_pkg::PCSL_MREPEATER));
         ifMode_nxt = rmiiStrap;
      end
      awRdy_nxt = !awHave_nxt;
      wRdy_nxt  = !wHave_nxt;
      arRdy_nxt = !rValid_nxt;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hwRstSeen_r  <= 1'b1;
         ctrl_r       <= pcsl_pkg::CFG_10HD;
         pd_r         <= 1'b0;
         adv_r        <= pcsl_pkg::ADV_RESET;
         addr_r       <= pcsl_pkg::ADDR_RESET;
         mode_r       <= pcsl_pkg::MODE_RESET;
         ifMode_r     <= 1'b0;
         strapLatch_r <= 7'h00;
         crsTx_r      <= 1'b1;
         rep_r        <= 1'b0;
         accept_r     <= 1'b0;
         start_r      <= 1'b0;
         awHave_r     <= 1'b0;
         wHave_r      <= 1'b0;
         awAddr_r     <= 4'h0;
         wData_r      <= 32'h0000_0000;
         wStrbOk_r    <= 1'b0;
         awRdy_r      <= 1'b0;
         wRdy_r       <= 1'b0;
         bValid_r     <= 1'b0;
         bResp_r      <= pcsl_pkg::RESP_OKAY;
         arRdy_r      <= 1'b0;
         rValid_r     <= 1'b0;
         rData_r      <= 32'h0000_0000;
         rResp_r      <= pcsl_pkg::RESP_OKAY;
      end else begin
         hwRstSeen_r  <= hwRstSeen_nxt;
         ctrl_r       <= ctrl_nxt;
         pd_r         <= pd_nxt;
         adv_r        <= adv_nxt;
         addr_r       <= addr_nxt;
         mode_r       <= mode_nxt;
         ifMode_r     <= ifMode_nxt;
         strapLatch_r <= strapLatch_nxt;
         crsTx_r      <= crsTx_nxt;
         rep_r        <= rep_nxt;
         accept_r     <= accept_nxt;
         start_r      <= start_nxt;
         awHave_r     <= awHave_nxt;
         wHave_r      <= wHave_nxt;
         awAddr_r     <= awAddr_nxt;
         wData_r      <= wData_nxt;
         wStrbOk_r    <= wStrbOk_nxt;
         awRdy_r      <= awRdy_nxt;
         wRdy_r       <= wRdy_nxt;
         bValid_r     <= bValid_nxt;
         bResp_r      <= bResp_nxt;
         arRdy_r      <= arRdy_nxt;
         rValid_r     <= rValid_nxt;
         rData_r      <= rData_nxt;
         rResp_r      <= rResp_nxt;
      end
   end

   assign tif.start        = start_r;
   assign frameAccept      = accept_r;
   assign speed100         = ctrl_r[3];
   assign anegEnable       = ctrl_r[2];
   assign isolate          = ctrl_r[1];
   assign fullDuplex       = ctrl_r[0];
   assign advAbility       = adv_r;
   assign powerDown        = pd_r;
   assign crsOnTransmit    = crsTx_r;
   assign repeaterMode     = rep_r;
   assign interfaceModeBit = ifMode_r;
   assign scramblerSeed    = addr_r;
   assign s_axi_awready    = awRdy_r;
   assign s_axi_wready     = wRdy_r;
   assign s_axi_bvalid     = bValid_r;
   assign s_axi_bresp      = bResp_r;
   assign s_axi_arready    = arRdy_r;
   assign s_axi_rvalid     = rValid_r;
   assign s_axi_rdata      = rData_r;
   assign s_axi_rresp      = rResp_r;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_ADDR_LOAD: assert property (loadPulse |=> addr_r == {2'b00, $past(addrStrap)})
      else $error("address not loaded from straps");
   AST_MATCH: assert property (frameValid && frameAddr != addr_r |=> !frameAccept)
      else $error("frame accepted at wrong address");
   AST_SEED: assert property (loadPulse |=> scramblerSeed == {2'b00, $past(addrStrap)})
      else $error("scrambler seed differs from address");
   AST_MODE_LOAD: assert property (loadPulse |=> {speed100, anegEnable, isolate, fullDuplex} == $past(dec[8:5]))
      else $error("control bits not loaded from mode strap");
   AST_PD_STRAP: assert property (loadPulse && modeStrap == 3'h6 |=> powerDown)
      else $error("power-down strap not applied");
   AST_SOFT_KEEP: assert property (tif.done && !hwReset && !loadPulse && !doWrite |=> $stable(ctrl_r) && $stable(addr_r))
      else $error("soft reset changed configuration");
   AST_IFMODE: assert property (loadPulse |=> interfaceModeBit == $past(rmiiStrap))
      else $error("interface mode not loaded");
   AST_LATCH_HOLD: assert property (!loadPulse |=> $stable(strapLatch_r))
      else $error("latched straps changed without reset");
   AST_ALL_CAP: assert property (loadPulse && modeStrap == 3'h7 |=> anegEnable && !isolate && advAbility == 4'hF)
      else $error("all-capable mode wrong");
   AST_SR_START: assert property (start_r |=> tif.busy [*8])
      else $error("soft reset did not start");

   COV_LOAD: cover property (loadPulse);
   COV_SOFT: cover property (start_r ##[1:1000] tif.done);
   COV_MATCH: cover property (frameAccept);
   COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ===== verif/pcsl_mac_model.sv
`timescale 1ns/1ps
// ****************************************
// Management side: frame address source
// ****************************************
module pcsl_mac_model (
   // Clock
   input  wire logic       clk,
   // Frame address towards the device
   output logic            frameValid,
   output logic [4:0]      frameAddr,
   input  wire logic       frameAccept
);
   logic       go = 1'b0;
   logic [4:0] reqAddr = 5'h00;
   initial begin
      frameValid = 1'b0;
      frameAddr = 5'h00;
   end
   // Idle address keeps toggling and comes back to the last request every other cycle; only frameValid marks a request
   always @(posedge clk) begin
      frameValid <= go;
      frameAddr <= go ? reqAddr : ~frameAddr;
   end
   task automatic send(input logic [4:0] a, output logic ok);
      @(negedge clk); go = 1'b1; reqAddr = a;
      @(negedge clk); go = 1'b0;
      @(posedge clk); @(negedge clk); ok = frameAccept;
   endtask
endmodule

// ===== verif/pcsl_top_tb.sv
`timescale 1ns/1ps
// ****************************************
// Strap loader bench
// ****************************************
module pcsl_top_tb;
   logic clk, srst, pinResetLow, rxErrPin, rxClkPin, rxd3Pin, rxd0Pin, rxd1Pin, colPin, reducedIfSelPin;
   logic frameValid, frameAccept, speed100, fullDuplex, anegEnable, isolate, powerDown, crsOnTransmit;
   logic repeaterMode, interfaceModeBit, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, acc;
   logic [4:0]  frameAddr, scramblerSeed;
   logic [3:0]  advAbility, s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, a;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [7:0]  e;
   logic [31:0] seed = 32'h7555_eba6;
   int          fails = 0, checks_done = 0, n, k, c;
   // Short soft reset keeps the run brief
   pcsl_top #(.SOFT_RESET_CYCLES(20)) uut (.clk, .srst, .pinResetLow, .rxErrPin, .rxClkPin, .rxd3Pin,
      .rxd0Pin, .rxd1Pin, .colPin, .reducedIfSelPin, .frameValid, .frameAddr, .frameAccept, .speed100,
      .fullDuplex, .anegEnable, .isolate, .advAbility, .powerDown, .crsOnTransmit, .repeaterMode,
      .interfaceModeBit, .scramblerSeed, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   pcsl_mac_model mac (.clk, .frameValid, .frameAddr, .frameAccept);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
      return seed;
   endfunction
   // Expected {ctrl 13,12,10,8 ; adv 8:5} per strap code
   function automatic logic [7:0] expCfg(input int m);
      case (m)
         1: return 8'h10;
         2: return 8'h80;
         3: return 8'h90;
         4, 5: return 8'hC4;
         7: return 8'hCF;
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks_done++;
      if (got !== ex) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic tmo(input int cnt);
      if (cnt >= 50) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic axw(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clk); s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      rsp = s_axi_bresp; s_axi_bready <= 0; tmo(n);
   endtask
   task automatic axr(input logic [3:0] ad);
      @(posedge clk); s_axi_araddr <= ad; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 0; tmo(n);
   endtask
   initial begin
      srst = 1; pinResetLow = 1; {rxErrPin, rxClkPin, rxd3Pin, rxd0Pin, rxd1Pin, colPin, reducedIfSelPin} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0; s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'hF;
      repeat (8) @(posedge clk);
      srst <= 0; repeat (6) @(posedge clk);
      chk("seed default", 0, scramblerSeed);
      axr(4'h2); chk("unmapped resp", 2, rsp);
      for (c = 0; c < 8; c++) begin
         a = xs(); e = expCfg(c);
         @(posedge clk); pinResetLow <= 0; {colPin, rxd1Pin, rxd0Pin} <= c[2:0];
         {rxd3Pin, rxClkPin, rxErrPin} <= a[2:0]; reducedIfSelPin <= a[3];
         repeat (6) @(posedge clk); pinResetLow <= 1; repeat (8) @(posedge clk);
         chk("ctrl", e[7:4], {speed100, anegEnable, isolate, fullDuplex});
         chk("adv", e[3:0], advAbility);
         chk("powerDown", c == 6, powerDown);
         chk("repeater", c == 5, repeaterMode);
         if (c inside {[2:5]}) chk("crs", c == 2 || c == 4, crsOnTransmit);
         chk("ifmode", a[3], interfaceModeBit);
         chk("seed", a[2:0], scramblerSeed);
         axr(pcsl_pkg::OFS_STRAPS); chk("straps", {a[3], c[2:0], a[2:0]}, {rd[8:5], rd[2:0]});
         mac.send({2'b00, a[2:0]}, acc); chk("accept", 1, acc);
         mac.send({2'b00, a[2:0] ^ 3'h1}, acc); chk("reject", 0, acc);
         axw(pcsl_pkg::OFS_SPECIAL, {24'h0, (c == 6) ? 3'h0 : c[2:0], 2'b10, a[2:0]});
         chk("wr resp", 0, rsp);
         mac.send({2'b10, a[2:0]}, acc); chk("new addr", 1, acc);
         chk("new seed", {2'b10, a[2:0]}, scramblerSeed);
         @(posedge clk); {colPin, rxd1Pin, rxd0Pin} <= ~c[2:0];
         axr(pcsl_pkg::OFS_CTRL); axw(pcsl_pkg::OFS_CTRL, rd | 32'h0000_8000);
         for (k = 0; k < 50; k++) begin
            axr(pcsl_pkg::OFS_CTRL);
            if (rd[15] === 1'b0) break;
         end
         tmo(k);
         if (c != 6) chk("soft ctrl", e[7:4], {speed100, anegEnable, isolate, fullDuplex});
         chk("soft pd", 0, powerDown);
         if (c inside {[2:5]}) chk("soft crs", c == 2 || c == 4, crsOnTransmit);
         chk("soft rep", c == 5, repeaterMode);
         axr(pcsl_pkg::OFS_STRAPS); chk("latched", c, rd[7:5]);
      end
      report_and_stop();
   end
endmodule
